// [tb/gpm_pad_model.sv]
// gpm_pad_model: pads and outside world of the gpio port
`timescale 1ns/100ps
`default_nettype none
module gpm_pad_model #(
	parameter logic PULL_LEVEL = 1'b1
) (
	input  wire logic        clk,
	input  wire logic [25:0] pad_out,
	input  wire logic [25:0] pad_oe,
	input  wire logic [25:0] pad_pull_en,
	input  wire logic [25:0] ext_level,
	input  wire logic [25:0] ext_en,
	output logic [25:0]      pad_in
);
	// a floating, unpulled pad flips every cycle so no stale level can pass
	logic [25:0] float_q = 26'h0;
	always @(posedge clk) begin
		float_q <= ~pad_in;
	end
	// device drive wins over the outside driver
	assign pad_in = (pad_oe & pad_out)
		| (~pad_oe & ext_en & ext_level)
		| (~pad_oe & ~ext_en & pad_pull_en & {26{PULL_LEVEL}})
		| (~pad_oe & ~ext_en & ~pad_pull_en & float_q);
endmodule
`default_nettype wire

// [tb/gpm_port_props.sv]
// gpm_port_props: port-level checks of the gpio port
`timescale 1ns/100ps
`default_nettype none
module gpm_port_props (
	input wire logic        clk,
	input wire logic        srst,
	input wire logic [6:0]  address,
	input wire logic        read,
	input wire logic        write,
	input wire logic [3:0]  byteenable,
	input wire logic [31:0] writedata,
	input wire logic [31:0] readdata,
	input wire logic        waitrequest,
	input wire logic [25:0] pad_in,
	input wire logic [25:0] pad_oe,
	input wire logic [25:0] pad_pull_en,
	input wire logic [25:0] pad_drive_hi,
	input wire logic [25:0] pin_level,
	input wire logic [31:0] timer_capture_sel,
	input wire logic        irq
);
	// ==========================================================
	// helpers: cycles since reset, last full-word write
	logic [2:0]  up_q;
	logic        done_q;
	logic [6:0]  wa_q;
	logic [31:0] wd_q;
	always_ff @(posedge clk) begin
		if (srst) up_q <= 3'h0;
		else if (up_q != 3'h7) up_q <= up_q + 3'h1;
	end
	always_ff @(posedge clk) begin
		done_q <= write & ~waitrequest & ~srst & (byteenable == 4'hf);
		if (write && !waitrequest) begin
			wa_q <= address;
			wd_q <= writedata;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	// ==========================================================
	// checks
	property p_wait; (read || write) && waitrequest |=> !waitrequest; endproperty
	a_wait: assert property (p_wait) else $error("no answer after one wait cycle");
	property p_rst; $fell(srst) |-> pad_oe == 26'h0 && pad_drive_hi == 26'h0 && timer_capture_sel == 32'h0; endproperty
	a_rst: assert property (p_rst) else $error("pad or timer reset value wrong");
	property p_pull_rst; $fell(srst) |-> pad_pull_en == 26'h3fffff; endproperty
	a_pull_rst: assert property (p_pull_rst) else $error("pull reset value wrong");
	property p_irq_rst; $fell(srst) |-> !irq && pin_level == 26'h0; endproperty
	a_irq_rst: assert property (p_irq_rst) else $error("irq not low after reset");
	property p_level; up_q == 3'h7 && $stable(pad_in) [*5] |-> pin_level == pad_in; endproperty
	a_level: assert property (p_level) else $error("pin level lags stable pad");
	property p_rd; read && !waitrequest && address == 7'h00 |-> readdata == {6'h0, $past(pin_level)}; endproperty
	a_rd: assert property (p_rd) else $error("data read is not pin level");
	property p_tcap; done_q && wa_q == 7'h44 |-> ##[0:1] timer_capture_sel == wd_q; endproperty
	a_tcap: assert property (p_tcap) else $error("capture select not updated");
	property p_pull; done_q && wa_q == 7'h08 |-> ##[0:1] pad_pull_en == wd_q[25:0]; endproperty
	a_pull: assert property (p_pull) else $error("pull pads not updated");
	property p_drive; done_q && wa_q == 7'h0c |-> ##[0:1] pad_drive_hi == wd_q[25:0]; endproperty
	a_drive: assert property (p_drive) else $error("drive pads not updated");
	c_read: cover property (read && !waitrequest);
	c_irq: cover property (irq);
	c_clear: cover property (done_q && wa_q == 7'h28);
endmodule
bind gpm_port gpm_port_props u_props (.clk(clk), .srst(srst), .address(address), .read(read), .write(write),
	.byteenable(byteenable), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
	.pad_in(pad_in), .pad_oe(pad_oe), .pad_pull_en(pad_pull_en), .pad_drive_hi(pad_drive_hi),
	.pin_level(pin_level), .timer_capture_sel(timer_capture_sel), .irq(irq));
`default_nettype wire

// [tb/tb_gpio_port_with_pin_mode_select.sv]
// tb_gpio_port_with_pin_mode_select: self-checking bench of the gpio port
`timescale 1ns/100ps
`default_nettype none
module tb_gpio_port_with_pin_mode_select;
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic [6:0]  address;
	logic        read, write;
	logic [3:0]  byteenable;
	logic [31:0] writedata, readdata, tcap;
	logic        waitrequest, irq;
	logic [25:0] pad_in, pad_out, pad_oe, pull, drive, lvl, ext_level, ext_en;
	logic [25:0] s1o, s1e, s2o, s2e, s3o, s3e;
	int          n_fail = 0;
	int          samples_checked = 0;
	int          cyc = 0;
	always #12.5 clk = ~clk;
	gpm_port dut (.clk(clk), .srst(srst), .address(address), .read(read), .write(write),
		.byteenable(byteenable), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
		.pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_en(pull), .pad_drive_hi(drive),
		.ser1_out(s1o), .ser1_oe(s1e), .ser2_out(s2o), .ser2_oe(s2e), .ser3_out(s3o), .ser3_oe(s3e),
		.pin_level(lvl), .timer_capture_sel(tcap), .irq(irq));
	gpm_pad_model pads (.clk(clk), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_en(pull),
		.ext_level(ext_level), .ext_en(ext_en), .pad_in(pad_in));
	// ==========================================================
	// bus and compare tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [31:0] d);
		address <= a;
		writedata <= d;
		write <= 1'b1;
		@(posedge clk);
		while (waitrequest !== 1'b0) @(posedge clk);
		write <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rdchk(input logic [6:0] a, input logic [31:0] exp, input string m);
		logic [31:0] d;
		address <= a;
		read <= 1'b1;
		@(posedge clk);
		while (waitrequest !== 1'b0) @(posedge clk);
		d = readdata;
		read <= 1'b0;
		@(posedge clk);
		chk(d, exp, m);
	endtask
	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic print_verdict();
		$display("checked %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// ==========================================================
	// scenarios
	task automatic t_reset_vals();
		rdchk(7'h04, 32'h0, "dir");
		rdchk(7'h08, 32'h003fffff, "pull");
		rdchk(7'h0c, 32'h0, "drive");
		rdchk(7'h10, 32'h0, "sense");
		rdchk(7'h14, 32'h0, "dual");
		rdchk(7'h18, 32'h0, "polarity");
		rdchk(7'h1c, 32'h0, "mask");
		rdchk(7'h30, 32'h00000110, "fsel b");
		rdchk(7'h34, 32'h0, "fsel c");
		rdchk(7'h38, 32'h0, "fsel d");
		rdchk(7'h44, 32'h0, "capture");
		rdchk(7'h48, 32'h0, "unmapped");
		chk(pull, 26'h3fffff, "pull pads");
		$display("test reset_vals done");
	endtask
	task automatic t_regs();
		for (int i = 1; i < 8; i++) begin
			wr(7'(i * 4), 32'ha5c3_5a3c ^ 32'(i));
			rdchk(7'(i * 4), 32'ha5c3_5a3c ^ 32'(i), "rw");
		end
		wait_clk(2);
		chk(drive, 26'h1c35a3f, "drive pads");
		for (int i = 11; i < 18; i++) wr(7'(i * 4), 32'h7777_7777);
		rdchk(7'h38, 32'h7777_7777, "fsel d");
		rdchk(7'h44, 32'h7777_7777, "capture");
		chk(tcap, 32'h7777_7777, "capture port");
		// lanes 0 and 2 only: bytes 1 and 3 keep their old value
		byteenable <= 4'h5;
		wr(7'h44, 32'h0);
		byteenable <= 4'hf;
		rdchk(7'h44, 32'h7700_7700, "lanes");
		rdchk(7'h3c, 32'h0, "set reads 0");
		rdchk(7'h40, 32'h0, "clear reads 0");
		wr(7'h48, 32'hffff_ffff);
		rdchk(7'h48, 32'h0, "unmapped");
		for (int i = 1; i < 18; i++) wr(7'(i * 4), 32'h0);
		$display("test regs done");
	endtask
	task automatic t_gpio();
		wr(7'h04, 32'h03ff_ffff);
		wr(7'h00, 32'h0155_5555);
		wait_clk(2);
		chk(pad_oe, 26'h3ffffff, "oe");
		chk(pad_out, 26'h1555555, "out");
		wait_clk(6);
		rdchk(7'h00, 32'h0155_5555, "data");
		wr(7'h3c, 32'h2);
		wr(7'h40, 32'h1);
		wr(7'h2c, 32'h4);
		wr(7'h3c, 32'h1);
		wr(7'h2c, 32'h0);
		wait_clk(2);
		chk(pad_out, 26'h1555556, "set clear");
		wr(7'h04, 32'h0);
		ext_level <= 26'h2aaaaaa;
		wait_clk(8);
		rdchk(7'h00, 32'h02aa_aaaa, "pin not data");
		$display("test gpio done");
	endtask
	task automatic t_fsel();
		logic [25:0] eo, ee;
		s1o <= 26'h2aaaaaa;
		s1e <= 26'h0f0f0f0;
		s2o <= 26'h1555555;
		s2e <= 26'h3c3c3c3;
		s3o <= 26'h3333333;
		s3e <= 26'h3ffffff;
		wr(7'h04, 32'h03ff_ffff);
		for (int c = 0; c < 8; c++) begin
			for (int r = 0; r < 4; r++) wr(7'h2c + 7'(r * 4), {8{1'b0, 3'(c)}});
			wait_clk(2);
			case (c)
				0: {eo, ee} = {26'h1555556, 26'h3ffffff};
				1: {eo, ee} = {s2o, s2e};
				4: {eo, ee} = {s1o, s1e};
				5: {eo, ee} = {s3o, s3e};
				default: {eo, ee} = 52'h0;
			endcase
			chk(pad_oe, ee, "fn oe");
			chk(pad_out, eo, "fn out");
		end
		for (int r = 0; r < 4; r++) wr(7'h2c + 7'(r * 4), 32'h0);
		$display("test fsel done");
	endtask
	task automatic t_irq();
		ext_level <= 26'h0;
		wr(7'h04, 32'h0);
		wr(7'h10, 32'h18);
		wr(7'h14, 32'h4);
		wr(7'h18, 32'h9);
		wait_clk(6);
		wr(7'h28, 32'h03ff_ffff);
		rdchk(7'h20, 32'h10, "raw idle");
		rdchk(7'h24, 32'h0, "masked idle");
		ext_level <= 26'h1f;
		wait_clk(8);
		rdchk(7'h20, 32'h1d, "raw rise");
		ext_level <= 26'h0;
		wait_clk(8);
		rdchk(7'h20, 32'h1f, "raw fall");
		wr(7'h28, 32'hf);
		rdchk(7'h20, 32'h10, "part clear");
		wr(7'h1c, 32'h3);
		wait_clk(2);
		chk(irq, 1'b0, "irq masked");
		wr(7'h1c, 32'h13);
		wait_clk(2);
		chk(irq, 1'b1, "irq on");
		rdchk(7'h24, 32'h10, "masked");
		ext_level <= 26'h10;
		wait_clk(6);
		wr(7'h28, 32'h10);
		wait_clk(2);
		rdchk(7'h24, 32'h0, "masked cleared");
		chk(irq, 1'b0, "irq off");
		$display("test irq done");
	endtask
	// ==========================================================
	// main sequence and hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			n_fail++;
			print_verdict();
		end
	end
	initial begin
		{address, read, write, writedata} = 41'h0;
		byteenable = 4'hf;
		{s1o, s1e, s2o, s2e, s3o, s3e} = 156'h0;
		ext_level = 26'h0;
		ext_en = 26'h3ffffff;
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		t_reset_vals();
		t_regs();
		t_gpio();
		t_fsel();
		t_irq();
		print_verdict();
	end
endmodule
`default_nettype wire

// [verilog/gpm_irq_det.sv]
// gpm_irq_det: one pin's interrupt condition and sticky raw flag
`timescale 1ns/100ps
`default_nettype none
module gpm_irq_det (
	input  wire logic clk,
	input  wire logic srst,
	input  wire logic level,
	input  wire logic sense_level,
	input  wire logic dual_edge,
	input  wire logic polarity,
	input  wire logic clr,
	output logic      raw_q
);

	logic       prev_q;
	logic [4:0] settle_q;
	logic       primed;
	logic       rise;
	logic fall;
	logic hit;

	// ==========================================================
	// condition
	// level restarts at 0 after reset and catches up with a high pad only
	// once the synchroniser refills; edges stay blind until then
	assign primed = settle_q[4];
	assign rise   = primed & level & ~prev_q;
	assign fall   = primed & ~level & prev_q;

	always_comb begin
		if (sense_level) begin
			hit = (level == polarity);
		end else if (dual_edge) begin
			hit = rise | fall;
		end else begin
			hit = polarity ? rise : fall;
		end
	end

	// ==========================================================
	// sticky flag, set beats clear
	always_ff @(posedge clk) begin
		if (srst) begin
			prev_q   <= 1'b0;
			settle_q <= '0;
			raw_q    <= 1'b0;
		end else begin
			prev_q   <= level;
			settle_q <= {settle_q[3:0], 1'b1};
			raw_q    <= hit | (raw_q & ~clr);
		end
	end

endmodule
`default_nettype wire

// [verilog/gpm_pkg.sv]
// gpm_pkg: shared constants of the pin-mode gpio port
package gpm_pkg;

	// ==========================================================
	// geometry
	localparam int unsigned NPINS    = 26;
	localparam int unsigned DW       = 32;
	localparam int unsigned AW       = 7;
	localparam int unsigned FSEL_W   = 3;
	localparam int unsigned FSEL_PITCH = 4;
	localparam int unsigned FSEL_PER_REG = 8;

	// ==========================================================
	// register byte offsets
	localparam logic [AW-1:0] OFS_PIN_DATA      = 7'h00;
	localparam logic [AW-1:0] OFS_PIN_DIRECTION = 7'h04;
	localparam logic [AW-1:0] OFS_PULL_CONTROL  = 7'h08;
	localparam logic [AW-1:0] OFS_DRIVE_STRENGTH = 7'h0c;
	localparam logic [AW-1:0] OFS_IRQ_SENSE     = 7'h10;
	localparam logic [AW-1:0] OFS_IRQ_DUAL_EDGE = 7'h14;
	localparam logic [AW-1:0] OFS_IRQ_POLARITY  = 7'h18;
	localparam logic [AW-1:0] OFS_IRQ_MASK      = 7'h1c;
	localparam logic [AW-1:0] OFS_RAW_IRQ       = 7'h20;
	localparam logic [AW-1:0] OFS_MASKED_IRQ    = 7'h24;
	localparam logic [AW-1:0] OFS_IRQ_CLEAR     = 7'h28;
	localparam logic [AW-1:0] OFS_FSEL_A        = 7'h2c;
	localparam logic [AW-1:0] OFS_FSEL_B        = 7'h30;
	localparam logic [AW-1:0] OFS_FSEL_C        = 7'h34;
	localparam logic [AW-1:0] OFS_FSEL_D        = 7'h38;
	localparam logic [AW-1:0] OFS_DATA_BIT_SET  = 7'h3c;
	localparam logic [AW-1:0] OFS_DATA_BIT_CLR  = 7'h40;
	localparam logic [AW-1:0] OFS_TIMER_CAP_SEL = 7'h44;

	// ==========================================================
	// reset values
	localparam logic [DW-1:0] RST_ZERO     = 32'h0000_0000;
	localparam logic [DW-1:0] RST_PULL     = 32'h003f_ffff;
	localparam logic [DW-1:0] RST_FSEL_B   = 32'h0000_0110;
	localparam logic [NPINS-1:0] RST_PINS  = 26'h000_0000;

	// ==========================================================
	// function select codes
	localparam logic [FSEL_W-1:0] FN_GPIO    = 3'h0;
	localparam logic [FSEL_W-1:0] FN_THIRD_SERIAL_FUNCTION = 3'h1;
	localparam logic [FSEL_W-1:0] FN_SECOND_SERIAL_FUNCTION = 3'h4;
	localparam logic [FSEL_W-1:0] FN_SERIAL3 = 3'h5;

endpackage

// [verilog/gpm_port.sv]
// gpm_port: 26-pin gpio port with function select, avalon-mm slave
// Function
// - fsel code 0 gpio, 1 second serial, 4 first serial, 5 third serial
// - third select register covers pins 16..23, reset to gpio
// - fourth select register covers pins 24 and 25 only, reset gpio
// - data register holds pins 0..25 in low bits of a word
// - written data drives a pin only in gpio function and output direction
// - reading data returns sampled pin levels, not written values
// - set register ones force data bits high for gpio pins
// - clear register ones force data bits low for gpio pins
// - direction bit: 0 input, 1 output; reset to input
// - pull bit: 0 off, 1 on; resets to printed value
// - drive bit: 0 low drive, 1 high drive; reset low
// - sense bit: 0 edge detection, 1 level detection
// - edge pins: 0 single edge, 1 both edges
// - polarity: 0 falling or low, 1 rising or high
// - mask bit: 0 blocks, 1 passes interrupt; reset blocked
// - masked status is raw status AND mask
// - selector picks timer capture pins; resets to zero
// - raw bit sets on matching condition and stays until cleared
// - interrupt clear ones clear raw and masked bits
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module gpm_port (
	input  wire logic                      clk,
	input  wire logic                      srst,
	// avalon-mm slave
	input  wire logic [gpm_pkg::AW-1:0]    address,
	input  wire logic                      read,
	input  wire logic                      write,
	input  wire logic [3:0]                byteenable,
	input  wire logic [gpm_pkg::DW-1:0]    writedata,
	output logic [gpm_pkg::DW-1:0]         readdata,
	output logic                           waitrequest,
	// pads
	input  wire logic [gpm_pkg::NPINS-1:0] pad_in,
	output logic [gpm_pkg::NPINS-1:0]      pad_out,
	output logic [gpm_pkg::NPINS-1:0]      pad_oe,
	output logic [gpm_pkg::NPINS-1:0]      pad_pull_en,
	output logic [gpm_pkg::NPINS-1:0]      pad_drive_hi,
	// serial peripherals and sampled pin levels
	input  wire logic [gpm_pkg::NPINS-1:0] ser1_out,
	input  wire logic [gpm_pkg::NPINS-1:0] ser1_oe,
	input  wire logic [gpm_pkg::NPINS-1:0] ser2_out,
	input  wire logic [gpm_pkg::NPINS-1:0] ser2_oe,
	input  wire logic [gpm_pkg::NPINS-1:0] ser3_out,
	input  wire logic [gpm_pkg::NPINS-1:0] ser3_oe,
	output logic [gpm_pkg::NPINS-1:0]      pin_level,
	// timers and interrupt
	output logic [gpm_pkg::DW-1:0]         timer_capture_sel,
	output logic                           irq
);

	localparam int unsigned NP = gpm_pkg::NPINS;
	localparam int unsigned DW = gpm_pkg::DW;

	// ==========================================================
	// bus handshake
	// one wait state; the access completes on the edge after ack_q rises
	logic          ack_q;
	logic          req;
	logic          wr_go;
	logic [DW-1:0] wmask;
	logic [DW-1:0] wval;

	assign req         = read | write;
	assign waitrequest = req & ~ack_q;
	assign wr_go       = write & ack_q;

	always_ff @(posedge clk) begin
		if (srst) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req & ~ack_q;
		end
	end

	always_comb begin
		for (int b = 0; b < 4; b++) begin
			wmask[b*8 +: 8] = {8{byteenable[b]}};
		end
		wval = writedata & wmask;
	end

	function automatic logic [DW-1:0] merge(input logic [DW-1:0] old,
	                                        input logic [DW-1:0] nw,
	                                        input logic [DW-1:0] m);
		merge = (old & ~m) | (nw & m);
	endfunction

	function automatic logic hit(input logic [gpm_pkg::AW-1:0] a,
	                             input logic [gpm_pkg::AW-1:0] ofs);
		hit = (a == ofs);
	endfunction

	// ==========================================================
	// configuration registers
	logic [DW-1:0] pin_direction_q;
	logic [DW-1:0] pull_control_q;
	logic [DW-1:0] drive_strength_q;
	logic [DW-1:0] irq_sense_select_q;
	logic [DW-1:0] irq_dual_edge_q;
	logic [DW-1:0] irq_polarity_q;
	logic [DW-1:0] irq_mask_q;
	logic [DW-1:0] timer_capture_pin_sel_q;

	always_ff @(posedge clk) begin
		if (srst) begin
			pin_direction_q <= gpm_pkg::RST_ZERO;
		end else if (wr_go && hit(address, gpm_pkg::OFS_PIN_DIRECTION)) begin
			pin_direction_q <= merge(pin_direction_q, writedata, wmask);
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			pull_control_q <= gpm_pkg::RST_PULL;
		end else if (wr_go && hit(address, gpm_pkg::OFS_PULL_CONTROL)) begin
			pull_control_q <= merge(pull_control_q, writedata, wmask);
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			drive_strength_q <= gpm_pkg::RST_ZERO;
		end else if (wr_go && hit(address, gpm_pkg::OFS_DRIVE_STRENGTH)) begin
			drive_strength_q <= merge(drive_strength_q, writedata, wmask);
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			irq_sense_select_q <= gpm_pkg::RST_ZERO;
			irq_dual_edge_q    <= gpm_pkg::RST_ZERO;
			irq_polarity_q     <= gpm_pkg::RST_ZERO;
		end else if (wr_go) begin
			if (hit(address, gpm_pkg::OFS_IRQ_SENSE)) begin
				irq_sense_select_q <= merge(irq_sense_select_q, writedata, wmask);
			end
			if (hit(address, gpm_pkg::OFS_IRQ_DUAL_EDGE)) begin
				irq_dual_edge_q <= merge(irq_dual_edge_q, writedata, wmask);
			end
			if (hit(address, gpm_pkg::OFS_IRQ_POLARITY)) begin
				irq_polarity_q <= merge(irq_polarity_q, writedata, wmask);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			irq_mask_q <= gpm_pkg::RST_ZERO;
		end else if (wr_go && hit(address, gpm_pkg::OFS_IRQ_MASK)) begin
			irq_mask_q <= merge(irq_mask_q, writedata, wmask);
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			timer_capture_pin_sel_q <= gpm_pkg::RST_ZERO;
		end else if (wr_go && hit(address, gpm_pkg::OFS_TIMER_CAP_SEL)) begin
			timer_capture_pin_sel_q <= merge(timer_capture_pin_sel_q, writedata, wmask);
		end
	end

	assign timer_capture_sel = timer_capture_pin_sel_q;

	// ==========================================================
	// function select registers
	logic [DW-1:0] fsel_q [4];
	logic [gpm_pkg::FSEL_W-1:0] fsel [NP];

	always_ff @(posedge clk) begin
		if (srst) begin
			fsel_q[0] <= gpm_pkg::RST_ZERO;
			fsel_q[1] <= gpm_pkg::RST_FSEL_B;
			fsel_q[2] <= gpm_pkg::RST_ZERO;
			fsel_q[3] <= gpm_pkg::RST_ZERO;
		end else if (wr_go) begin
			if (hit(address, gpm_pkg::OFS_FSEL_A)) begin
				fsel_q[0] <= merge(fsel_q[0], writedata, wmask);
			end
			if (hit(address, gpm_pkg::OFS_FSEL_B)) begin
				fsel_q[1] <= merge(fsel_q[1], writedata, wmask);
			end
			if (hit(address, gpm_pkg::OFS_FSEL_C)) begin
				fsel_q[2] <= merge(fsel_q[2], writedata, wmask);
			end
			if (hit(address, gpm_pkg::OFS_FSEL_D)) begin
				fsel_q[3] <= merge(fsel_q[3], writedata, wmask);
			end
		end
	end

	// ==========================================================
	// data register with set and clear companions
	logic [NP-1:0] pin_data_q;
	logic [NP-1:0] is_gpio;
	logic [NP-1:0] set_bits;
	logic [NP-1:0] clr_bits;

	assign set_bits = (wr_go && hit(address, gpm_pkg::OFS_DATA_BIT_SET)) ? wval[NP-1:0] & is_gpio : '0;
	assign clr_bits = (wr_go && hit(address, gpm_pkg::OFS_DATA_BIT_CLR)) ? wval[NP-1:0] & is_gpio : '0;

	always_ff @(posedge clk) begin
		if (srst) begin
			pin_data_q <= gpm_pkg::RST_PINS;
		end else if (wr_go && hit(address, gpm_pkg::OFS_PIN_DATA)) begin
			pin_data_q <= (pin_data_q & ~wmask[NP-1:0]) | (writedata[NP-1:0] & wmask[NP-1:0]);
		end else begin
			pin_data_q <= (pin_data_q | set_bits) & ~clr_bits;
		end
	end

	// ==========================================================
	// pad input sampling
	gpm_sync #(
		.W (NP)
	) u_sync (
		.clk      (clk),
		.srst     (srst),
		.async_in (pad_in),
		.level_q  (pin_level)
	);

	// ==========================================================
	// per-pin routing and interrupt detection
	logic [NP-1:0] raw_irq_status;
	logic [NP-1:0] masked_irq_status;
	logic [NP-1:0] irq_clr;
	logic [NP-1:0] out_d;
	logic [NP-1:0] oe_d;

	assign irq_clr = (wr_go && hit(address, gpm_pkg::OFS_IRQ_CLEAR)) ? wval[NP-1:0] : '0;

	for (genvar p = 0; p < NP; p++) begin : g_pin
		localparam int unsigned R = p / gpm_pkg::FSEL_PER_REG;
		localparam int unsigned F = (p % gpm_pkg::FSEL_PER_REG) * gpm_pkg::FSEL_PITCH;

		assign fsel[p]    = fsel_q[R][F +: gpm_pkg::FSEL_W];
		assign is_gpio[p] = (fsel[p] == gpm_pkg::FN_GPIO);

		// illegal codes leave the pin as an undriven input
		always_comb begin
			unique case (fsel[p])
				gpm_pkg::FN_GPIO: begin
					out_d[p] = pin_data_q[p];
					oe_d[p]  = pin_direction_q[p];
				end
				gpm_pkg::FN_THIRD_SERIAL_FUNCTION: begin
					out_d[p] = ser2_out[p];
					oe_d[p]  = ser2_oe[p];
				end
				gpm_pkg::FN_SECOND_SERIAL_FUNCTION: begin
					out_d[p] = ser1_out[p];
					oe_d[p]  = ser1_oe[p];
				end
				gpm_pkg::FN_SERIAL3: begin
					out_d[p] = ser3_out[p];
					oe_d[p]  = ser3_oe[p];
				end
				default: begin
					out_d[p] = 1'b0;
					oe_d[p]  = 1'b0;
				end
			endcase
		end

		gpm_irq_det u_det (
			.clk         (clk),
			.srst        (srst),
			.level       (pin_level[p]),
			.sense_level (irq_sense_select_q[p]),
			.dual_edge   (irq_dual_edge_q[p]),
			.polarity    (irq_polarity_q[p]),
			.clr         (irq_clr[p]),
			.raw_q       (raw_irq_status[p])
		);
	end

	assign masked_irq_status = raw_irq_status & irq_mask_q[NP-1:0];

	// ==========================================================
	// pad outputs, registered
	localparam logic [NP-1:0] RST_PULL_PINS = gpm_pkg::RST_PULL[NP-1:0];

	always_ff @(posedge clk) begin
		if (srst) begin
			pad_out      <= '0;
			pad_oe       <= '0;
			pad_pull_en  <= RST_PULL_PINS;
			pad_drive_hi <= '0;
		end else begin
			pad_out      <= out_d;
			pad_oe       <= oe_d;
			pad_pull_en  <= pull_control_q[NP-1:0];
			pad_drive_hi <= drive_strength_q[NP-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			irq <= 1'b0;
		end else begin
			irq <= |masked_irq_status;
		end
	end

	// ==========================================================
	// read path
	// set, clear and irq-clear are action registers and read as zero
	logic [DW-1:0] rd_d;

	always_comb begin
		rd_d = '0;
		unique case (address)
			gpm_pkg::OFS_PIN_DATA:       rd_d[NP-1:0] = pin_level;
			gpm_pkg::OFS_PIN_DIRECTION:  rd_d = pin_direction_q;
			gpm_pkg::OFS_PULL_CONTROL:   rd_d = pull_control_q;
			gpm_pkg::OFS_DRIVE_STRENGTH: rd_d = drive_strength_q;
			gpm_pkg::OFS_IRQ_SENSE:      rd_d = irq_sense_select_q;
			gpm_pkg::OFS_IRQ_DUAL_EDGE:  rd_d = irq_dual_edge_q;
			gpm_pkg::OFS_IRQ_POLARITY:   rd_d = irq_polarity_q;
			gpm_pkg::OFS_IRQ_MASK:       rd_d = irq_mask_q;
			gpm_pkg::OFS_RAW_IRQ:        rd_d[NP-1:0] = raw_irq_status;
			gpm_pkg::OFS_MASKED_IRQ:     rd_d[NP-1:0] = masked_irq_status;
			gpm_pkg::OFS_FSEL_A:         rd_d = fsel_q[0];
			gpm_pkg::OFS_FSEL_B:         rd_d = fsel_q[1];
			gpm_pkg::OFS_FSEL_C:         rd_d = fsel_q[2];
			gpm_pkg::OFS_FSEL_D:         rd_d = fsel_q[3];
			gpm_pkg::OFS_TIMER_CAP_SEL:  rd_d = timer_capture_pin_sel_q;
			default:                     rd_d = '0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			readdata <= '0;
		end else if (read && !ack_q) begin
			readdata <= rd_d;
		end
	end

endmodule
`default_nettype wire

// [verilog/gpm_sync.sv]
// gpm_sync: three-stage pad synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module gpm_sync #(
	parameter int unsigned W = 1
) (
	input  wire logic         clk,
	input  wire logic         srst,
	input  wire logic [W-1:0] async_in,
	output logic [W-1:0]      level_q
);

	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	// ==========================================================
	// chain
	always_ff @(posedge clk) begin
		if (srst) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= async_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// a change counts only once stages two and three agree
	always_ff @(posedge clk) begin
		if (srst) begin
			level_q <= '0;
		end else begin
			for (int i = 0; i < W; i++) begin
				if (s2_q[i] == s3_q[i]) begin
					level_q[i] <= s3_q[i];
				end
			end
		end
	end

endmodule
`default_nettype wire
